// File: verilog/seia_top.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Functional notes
// R1: EEPROM done flag set on finish, W1C
// R2: Kind bit picks write (0) or read (1)
// R3: Pin data shows fetched inputs, supplied outputs
// R4: Override mode supplies software output values
// R5: Input bits of pin data never writable
// R6: Refresh trigger launches expander SMBus transaction
// R7: Refresh trigger always reads back zero
// R8: Select codes 0,2,4 pick expanders
// R9: Data byte write starts EEPROM access
// R10: Busy high while EEPROM access runs
// R11: Expander done flag on refresh/update finish
// R12: Expander addressed by its slave address field
// R13: Reserved select: no transaction, zero data
module seia_top #(
  parameter logic [6:0] EEPROM_SMB_ADDR = 7'h00
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [11:0]           s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       smb_req_valid,
  input  wire logic                  smb_req_ready,
  output seia_pkg::seia_smb_req_t    smb_req,
  input  wire seia_pkg::seia_smb_rsp_t smb_rsp,
  input  wire logic [2:0][15:0]      core_exp_out,
  input  wire logic [15:0]           expander_input_mask,
  output logic                       irq
);

  seia_pkg::seia_regbus_t  bus;
  logic [31:0]             rd_data;
  seia_pkg::seia_state_t   state_q;
  seia_pkg::seia_smb_req_t req_q;
  logic [1:0]              exp_idx_q;
  logic [15:0]             ee_addr_q;
  logic [7:0]              ee_data_q;
  logic                    ee_busy_q;
  logic                    ee_done_q;
  logic                    ee_op_q;
  logic                    io_tm_q;
  logic [2:0]              io_sel_q;
  logic                    io_done_q;
  logic [2:0][6:0]         exp_addr_q;
  logic [2:0][15:0]        pin_q;
  logic [2:0][15:0]        sw_out_q;
  logic [1:0]              irq_en_q;
  logic [1:0]              irq_stat_q;
  logic                    wr_ee;
  logic                    wr_io;
  logic                    idle;
  logic [2:0]              sel_new;
  logic                    tm_new;
  logic                    op_new;
  logic [2:0]              sel_dec_new;
  logic [2:0]              sel_dec_cur;
  logic [15:0]             sw_new;
  logic [15:0]             out_supply;
  logic                    ee_launch;
  logic                    exp_refresh;
  logic                    exp_update;
  logic                    finish;
  logic                    ee_finish;
  logic                    exp_finish;

  // Select decode: {valid, index}; reserved codes come back invalid
  function automatic logic [2:0] sel_decode(input logic [2:0] sel);
    logic [2:0] r;
    r = 3'b000;
    case (sel)
      seia_pkg::SEL_EXP0: r = 3'b100;
      seia_pkg::SEL_EXP2: r = 3'b101;
      seia_pkg::SEL_EXP4: r = 3'b110;
      default:            r = 3'b000;
    endcase
    return r;
  endfunction

  // Byte-lane merge for the low half-word of a register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
    return {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  seia_axil_slave u_axil (
    .clk           (clk),
    .reset_n       (reset_n),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .bus           (bus),
    .rd_data       (rd_data)
  );

  // Write decode; fields written in the same beat take effect at once
  assign wr_ee       = bus.wr && (bus.waddr == seia_pkg::EEPROM_OFF);
  assign wr_io       = bus.wr && (bus.waddr == seia_pkg::IOEXP_OFF);
  assign idle        = (state_q == seia_pkg::ST_IDLE);
  assign sel_new     = bus.strb[3] ? bus.wdata[seia_pkg::IO_SEL_LSB +: 3] : io_sel_q;
  assign tm_new      = bus.strb[3] ? bus.wdata[seia_pkg::IO_TM_BIT] : io_tm_q;
  assign op_new      = bus.strb[3] ? bus.wdata[seia_pkg::EE_OP_BIT] : ee_op_q;
  assign sel_dec_new = sel_decode(sel_new);            // [R8]
  assign sel_dec_cur = sel_decode(io_sel_q);
  // Input bits are masked off so software can never set them [R5]
  assign sw_new      = merge16(sw_out_q[sel_dec_new[1:0]], bus.wdata[15:0], bus.strb[1:0])
                       & ~expander_input_mask;
  // Override replaces the core's output values [R4]
  assign out_supply  = tm_new ? sw_new : (core_exp_out[sel_dec_new[1:0]] & ~expander_input_mask);

  // Launch conditions; requests arriving while the engine is busy are dropped
  assign ee_launch   = wr_ee && bus.strb[2] && idle;   // [R9]
  assign exp_refresh = wr_io && bus.strb[3] && bus.wdata[seia_pkg::IO_RELOAD_BIT]
                       && sel_dec_new[2] && idle;       // [R6] [R13]
  assign exp_update  = wr_io && (|bus.strb[1:0]) && tm_new && sel_dec_new[2]
                       && idle && !exp_refresh;         // [R4] [R13]

  assign finish      = (state_q == seia_pkg::ST_WAIT) && smb_rsp.done;
  assign ee_finish   = finish && (req_q.kind == seia_pkg::SMB_EE_WRITE
                                  || req_q.kind == seia_pkg::SMB_EE_READ);
  assign exp_finish  = finish && !ee_finish;
  assign smb_req_valid = (state_q == seia_pkg::ST_REQ);
  assign smb_req       = req_q;

  // Transaction sequencer: one SMBus transaction outstanding at a time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= seia_pkg::ST_IDLE;
      req_q     <= '0;
      exp_idx_q <= 2'h0;
    end else begin
      case (state_q)
        seia_pkg::ST_IDLE: begin
          if (ee_launch) begin
            req_q.kind       <= (op_new == seia_pkg::OP_READ) ? seia_pkg::SMB_EE_READ
                                                             : seia_pkg::SMB_EE_WRITE; // [R2]
            req_q.slave_addr <= EEPROM_SMB_ADDR;
            req_q.mem_addr   <= merge16(ee_addr_q, bus.wdata[15:0], bus.strb[1:0]);
            req_q.wdata      <= {8'h00, bus.wdata[seia_pkg::EE_DATA_LSB +: 8]};
            state_q          <= seia_pkg::ST_REQ;
          end else if (exp_refresh || exp_update) begin
            req_q.kind       <= exp_refresh ? seia_pkg::SMB_EXP_REFRESH
                                            : seia_pkg::SMB_EXP_UPDATE;
            req_q.slave_addr <= exp_addr_q[sel_dec_new[1:0]]; // [R12]
            req_q.mem_addr   <= seia_pkg::ZERO16;
            req_q.wdata      <= out_supply;                  // [R4]
            exp_idx_q        <= sel_dec_new[1:0];
            state_q          <= seia_pkg::ST_REQ;
          end
        end
        seia_pkg::ST_REQ: begin
          if (smb_req_ready) begin
            state_q <= seia_pkg::ST_WAIT;
          end
        end
        seia_pkg::ST_WAIT: begin
          if (smb_rsp.done) begin
            state_q <= seia_pkg::ST_IDLE;
          end
        end
        default: state_q <= seia_pkg::ST_IDLE;
      endcase
    end
  end

  // EEPROM access register; done flag set beats a same-cycle clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ee_addr_q <= seia_pkg::ZERO16;
      ee_data_q <= 8'h00;
      ee_busy_q <= 1'b0;
      ee_done_q <= 1'b0;
      ee_op_q   <= seia_pkg::OP_WRITE;
    end else begin
      if (wr_ee) begin
        ee_addr_q <= merge16(ee_addr_q, bus.wdata[15:0], bus.strb[1:0]);
        ee_op_q   <= op_new;
      end
      if (ee_launch) begin
        ee_data_q <= bus.wdata[seia_pkg::EE_DATA_LSB +: 8];
        ee_busy_q <= 1'b1;                              // [R10]
      end else if (ee_finish) begin
        ee_busy_q <= 1'b0;                              // [R10]
        if (req_q.kind == seia_pkg::SMB_EE_READ) begin
          ee_data_q <= smb_rsp.rdata[7:0];              // [R9]
        end
      end
      if (ee_finish) begin
        ee_done_q <= 1'b1;                              // [R1]
      end else if (wr_ee && bus.strb[3] && bus.wdata[seia_pkg::EE_DONE_BIT]) begin
        ee_done_q <= 1'b0;                              // [R1]
      end
    end
  end

  // Expander control, addresses and software output values
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_tm_q    <= 1'b0;
      io_sel_q   <= seia_pkg::SEL_EXP0;
      io_done_q  <= 1'b0;
      exp_addr_q <= '0;
      sw_out_q   <= '0;
    end else begin
      if (wr_io && bus.strb[3]) begin
        io_tm_q  <= tm_new;
        io_sel_q <= sel_new;
      end
      if (wr_io && (|bus.strb[1:0]) && sel_dec_new[2]) begin
        sw_out_q[sel_dec_new[1:0]] <= sw_new;           // [R5]
      end
      if (exp_finish) begin
        io_done_q <= 1'b1;                              // [R11]
      end else if (wr_io && bus.strb[3] && bus.wdata[seia_pkg::IO_DONE_BIT]) begin
        io_done_q <= 1'b0;                              // [R11]
      end
      if (bus.wr && bus.waddr == seia_pkg::EXPADDR0_OFF) begin
        if (bus.strb[0]) exp_addr_q[0] <= bus.wdata[seia_pkg::EXPA_LO_LSB +: 7];
        if (bus.strb[2]) exp_addr_q[1] <= bus.wdata[seia_pkg::EXPA_HI_LSB +: 7];
      end
      if (bus.wr && bus.waddr == seia_pkg::EXPADDR1_OFF && bus.strb[0]) begin
        exp_addr_q[2] <= bus.wdata[seia_pkg::EXPA_LO_LSB +: 7];
      end
    end
  end

  // Pin image: inputs as fetched, outputs as last supplied
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= '0;
    end else if (exp_finish) begin
      if (req_q.kind == seia_pkg::SMB_EXP_REFRESH) begin
        pin_q[exp_idx_q] <= (smb_rsp.rdata & expander_input_mask)
                            | (req_q.wdata & ~expander_input_mask);   // [R3] [R6]
      end else begin
        pin_q[exp_idx_q] <= (pin_q[exp_idx_q] & expander_input_mask)
                            | (req_q.wdata & ~expander_input_mask);   // [R3]
      end
    end
  end

  // Interrupt status, enable and clear; a new event outlives its clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_en_q   <= 2'h0;
      irq_stat_q <= 2'h0;
    end else begin
      if (bus.wr && bus.waddr == seia_pkg::IRQ_EN_OFF && bus.strb[0]) begin
        irq_en_q <= bus.wdata[seia_pkg::IRQ_W-1:0];
      end
      irq_stat_q <= ({exp_finish, ee_finish})
                    | (irq_stat_q & ~((bus.wr && bus.waddr == seia_pkg::IRQ_CLR_OFF
                                       && bus.strb[0]) ? bus.wdata[seia_pkg::IRQ_W-1:0]
                                                       : 2'h0));
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_data = seia_pkg::ZERO32;
    case (bus.raddr)
      seia_pkg::EEPROM_OFF: begin
        rd_data[15:0]                           = ee_addr_q;
        rd_data[seia_pkg::EE_DATA_LSB +: 8]     = ee_data_q;
        rd_data[seia_pkg::EE_BUSY_BIT]          = ee_busy_q;
        rd_data[seia_pkg::EE_DONE_BIT]          = ee_done_q;
        rd_data[seia_pkg::EE_OP_BIT]            = ee_op_q;
      end
      seia_pkg::IOEXP_OFF: begin
        rd_data[15:0] = sel_dec_cur[2] ? pin_q[sel_dec_cur[1:0]] : seia_pkg::ZERO16; // [R13]
        rd_data[seia_pkg::IO_RELOAD_BIT]        = 1'b0;      // [R7]
        rd_data[seia_pkg::IO_TM_BIT]            = io_tm_q;
        rd_data[seia_pkg::IO_SEL_LSB +: 3]      = io_sel_q;
        rd_data[seia_pkg::IO_DONE_BIT]          = io_done_q;
      end
      seia_pkg::EXPADDR0_OFF: begin
        rd_data[seia_pkg::EXPA_LO_LSB +: 7]     = exp_addr_q[0];
        rd_data[seia_pkg::EXPA_HI_LSB +: 7]     = exp_addr_q[1];
      end
      seia_pkg::EXPADDR1_OFF: rd_data[seia_pkg::EXPA_LO_LSB +: 7] = exp_addr_q[2];
      seia_pkg::IRQ_STAT_OFF: rd_data[seia_pkg::IRQ_W-1:0]        = irq_stat_q;
      seia_pkg::IRQ_EN_OFF:   rd_data[seia_pkg::IRQ_W-1:0]        = irq_en_q;
      default:                rd_data = seia_pkg::ZERO32;
    endcase
  end

  // Checks on the register and sequencing behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence ee_start_s;
    ee_launch;
  endsequence

  sequence exp_start_s;
    exp_refresh || exp_update;
  endsequence

  ee_done_set_a: assert property (ee_finish |=> ee_done_q && !ee_busy_q) // [R1]
    else $error("EEPROM done not flagged after finish");
  ee_kind_a: assert property (ee_start_s ##0 (op_new == seia_pkg::OP_READ)
      |=> smb_req_valid && req_q.kind == seia_pkg::SMB_EE_READ)  // [R2]
    else $error("EEPROM read kind not issued");
  ee_busy_a: assert property (ee_start_s |=> ee_busy_q [*2])  // [R10]
    else $error("EEPROM busy not held after launch");
  override_a: assert property (exp_update |=> smb_req_valid
      && req_q.wdata == sw_out_q[exp_idx_q])  // [R4]
    else $error("Override values not supplied");
  input_ro_a: assert property (smb_req_valid && req_q.kind == seia_pkg::SMB_EXP_UPDATE
      |-> (req_q.wdata & expander_input_mask) == seia_pkg::ZERO16)  // [R5]
    else $error("Input bits driven to expander");
  refresh_go_a: assert property (exp_refresh |=> smb_req_valid
      && req_q.kind == seia_pkg::SMB_EXP_REFRESH)  // [R6]
    else $error("Refresh did not launch");
  reload_zero_a: assert property (bus.rd && bus.raddr == seia_pkg::IOEXP_OFF
      |=> s_axi_rvalid && !s_axi_rdata[seia_pkg::IO_RELOAD_BIT])  // [R7]
    else $error("Refresh trigger read back nonzero");
  exp_done_a: assert property (exp_finish |=> io_done_q ##1 io_done_q || $past(wr_io)) // [R11]
    else $error("Expander done not flagged");
  exp_addr_a: assert property (exp_start_s |=> req_q.slave_addr == exp_addr_q[exp_idx_q]) // [R12]
    else $error("Wrong expander slave address");
  reserved_sel_a: assert property (wr_io && !sel_dec_new[2] && idle
      |=> !smb_req_valid)  // [R13]
    else $error("Transaction issued on reserved select");

endmodule

// File: verilog/seia_pkg.sv
package seia_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] EEPROM_OFF   = 12'h42C;
  localparam logic [11:0] IOEXP_OFF    = 12'h430;
  localparam logic [11:0] EXPADDR0_OFF = 12'h434;
  localparam logic [11:0] EXPADDR1_OFF = 12'h438;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h440;
  localparam logic [11:0] IRQ_EN_OFF   = 12'h444;
  localparam logic [11:0] IRQ_CLR_OFF  = 12'h448;

  // serial_eeprom_access_upper field positions
  localparam int EE_DATA_LSB = 16;
  localparam int EE_BUSY_BIT = 24;
  localparam int EE_DONE_BIT = 25;
  localparam int EE_OP_BIT   = 26;

  // io_expander_control field positions
  localparam int IO_RELOAD_BIT = 24;
  localparam int IO_TM_BIT     = 25;
  localparam int IO_SEL_LSB    = 28;
  localparam int IO_DONE_BIT   = 31;

  // Expander slave address field positions
  localparam int EXPA_LO_LSB = 1;
  localparam int EXPA_HI_LSB = 17;

  // Expander select codes and eeprom_access_kind values
  localparam logic [2:0] SEL_EXP0 = 3'h0;
  localparam logic [2:0] SEL_EXP2 = 3'h2;
  localparam logic [2:0] SEL_EXP4 = 3'h4;
  localparam logic       OP_WRITE = 1'b0;
  localparam logic       OP_READ  = 1'b1;

  // Interrupt status bits
  localparam int IRQ_EE_BIT  = 0;
  localparam int IRQ_EXP_BIT = 1;
  localparam int IRQ_W       = 2;

  // Reset values
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;

  typedef enum logic [1:0] {
    SMB_EE_WRITE    = 2'h0,
    SMB_EE_READ     = 2'h1,
    SMB_EXP_REFRESH = 2'h2,
    SMB_EXP_UPDATE  = 2'h3
  } seia_smb_kind_t;

  // One-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_WAIT = 3'b100
  } seia_state_t;

  // Transaction handed to the master SMBus engine
  typedef struct packed {
    seia_smb_kind_t kind;
    logic [6:0]     slave_addr;
    logic [15:0]    mem_addr;
    logic [15:0]    wdata;
  } seia_smb_req_t;

  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } seia_smb_rsp_t;

  // Register strobes from the bus slave
  typedef struct packed {
    logic        wr;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic        rd;
    logic [11:0] raddr;
  } seia_regbus_t;

endpackage

// File: verilog/seia_axil_slave.sv
`timescale 1ns/1ns
module seia_axil_slave (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [11:0]         s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output seia_pkg::seia_regbus_t   bus,
  input  wire logic [31:0]         rd_data
);

  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic        wr_fire;

  // Address and data are taken in either order, one write at a time
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign wr_fire       = aw_held_q && w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = seia_pkg::RESP_OKAY;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = seia_pkg::RESP_OKAY;

  // Register strobes; read strobe coincides with the address handshake
  always_comb begin
    bus.wr    = wr_fire;
    bus.waddr = awaddr_q;
    bus.wdata = wdata_q;
    bus.strb  = wstrb_q;
    bus.rd    = s_axi_arvalid && !rvalid_q;
    bus.raddr = s_axi_araddr;
  end

  // Write channel holding registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= seia_pkg::ZERO32;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data captured at the address handshake
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= seia_pkg::ZERO32;
    end else if (bus.rd) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// File: tb/seia_smb_model.sv
`timescale 1ns/1ns
// SMBus engine stand-in: one job at a time, EEPROM writes answer slowly
module seia_smb_model (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    smb_req_valid,
  input  wire seia_pkg::seia_smb_req_t smb_req,
  output logic                         smb_req_ready,
  output seia_pkg::seia_smb_rsp_t      smb_rsp
);
  seia_pkg::seia_smb_req_t job_q;
  logic [4:0]              cnt_q;
  logic                    busy_q;

  // Accept when idle, then pulse done once after the latency
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      smb_req_ready <= 1'b0;
      smb_rsp       <= '0;
      job_q         <= '0;
      cnt_q         <= 5'h00;
      busy_q        <= 1'b0;
    end else begin
      smb_req_ready <= !busy_q && smb_req_valid && !smb_req_ready;
      smb_rsp.done  <= 1'b0;
      smb_rsp.rdata <= ~smb_rsp.rdata;  // Idle data wobbles, no stale match
      if (smb_req_valid && smb_req_ready) begin
        busy_q <= 1'b1;
        job_q  <= smb_req;
        cnt_q  <= (smb_req.kind == seia_pkg::SMB_EE_WRITE) ? 5'h14 : 5'h02;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h00) begin
          busy_q        <= 1'b0;
          smb_rsp.done  <= 1'b1;
          smb_rsp.rdata <= (job_q.kind == seia_pkg::SMB_EE_READ) ?
            16'hA5C3 ^ job_q.mem_addr : 16'h3C5A ^ {9'h000, job_q.slave_addr};
        end
      end
    end
  end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic                    clk, reset_n, irq, smb_req_valid, smb_req_ready;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready;
  logic [11:0]             s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic [2:0][15:0]        core_exp_out;
  logic [15:0]             expander_input_mask;
  logic [6:0]              sa [3] = '{7'h21, 7'h22, 7'h24};
  seia_pkg::seia_smb_req_t smb_req, lr;
  seia_pkg::seia_smb_rsp_t smb_rsp;
  int                      err_count, n_compared, cyc, nq, nq0;

  seia_top #(.EEPROM_SMB_ADDR(7'h50)) u_dut (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .smb_req_valid, .smb_req_ready, .smb_req,
    .smb_rsp, .core_exp_out, .expander_input_mask, .irq);
  seia_smb_model u_smb (.clk, .reset_n, .smb_req_valid, .smb_req, .smb_req_ready, .smb_rsp);

  always #5 clk = ~clk;

  // Snoop accepted jobs; a hang ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (smb_req_valid && smb_req_ready) begin
      lr <= smb_req;
      nq <= nq + 1;
    end
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic ck(input string n, input logic [40:0] e, input logic [40:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    ck("bresp", 0, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    ck("rresp", 0, s_axi_rresp);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wirq();
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    core_exp_out = {16'h00EE, 16'h00EE, 16'h00EE};
    expander_input_mask = 16'hFF00;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rdr(12'h7FC);
    ck("unmapped", 0, rd);
    wr(seia_pkg::IRQ_EN_OFF, 32'h0000_0003, 4'hF);
    // EEPROM write; partner is slow so busy is seen
    wr(seia_pkg::EEPROM_OFF, 32'h005A_0012, 4'hF);
    rdr(seia_pkg::EEPROM_OFF);
    ck("ee busy", 32'h015A_0012, rd);
    wirq();
    ck("ee job", {2'h0, 7'h50, 16'h0012, 8'h5A}, {lr.kind, lr.slave_addr, lr.mem_addr, lr.wdata[7:0]});
    rdr(seia_pkg::EEPROM_OFF);
    ck("ee done", 32'h025A_0012, rd);
    wr(seia_pkg::EEPROM_OFF, 32'h0200_0000, 4'h8);
    wr(seia_pkg::IRQ_CLR_OFF, 32'h0000_0001, 4'hF);
    rdr(seia_pkg::EEPROM_OFF);
    ck("ee clr", 32'h005A_0012, rd);
    // EEPROM read: written byte ignored, fetched byte shown
    wr(seia_pkg::EEPROM_OFF, 32'h04FF_0034, 4'hF);
    wirq();
    rdr(seia_pkg::EEPROM_OFF);
    ck("ee read", 32'h06F7_0034, rd);
    wr(seia_pkg::IRQ_CLR_OFF, 32'h0000_0001, 4'hF);
    wr(seia_pkg::EXPADDR0_OFF, 32'h0044_0042, 4'hF);
    wr(seia_pkg::EXPADDR1_OFF, 32'h0000_0048, 4'hF);
    // Refresh each expander in turn
    for (int i = 0; i < 3; i++) begin
      wr(seia_pkg::IOEXP_OFF, {1'b0, 3'(2 * i), 4'h1, 24'h0}, 4'h8);
      wirq();
      ck("exp job", {2'h2, sa[i]}, {lr.kind, lr.slave_addr});
      rdr(seia_pkg::IOEXP_OFF);
      ck("exp rd", {1'b1, 3'(2 * i), 12'h0, ((16'h3C5A ^ {9'h0, sa[i]}) & 16'hFF00) | 16'h00EE},
         rd);
      wr(seia_pkg::IOEXP_OFF, {1'b1, 3'(2 * i), 28'h0}, 4'h8);
      wr(seia_pkg::IRQ_CLR_OFF, 32'h0000_0002, 4'hF);
    end
    // Override: software outputs go out, input bits stay
    wr(seia_pkg::IOEXP_OFF, 32'h2200_1234, 4'hF);
    wirq();
    ck("upd job", {2'h3, 7'h22, 16'h0034}, {lr.kind, lr.slave_addr, lr.wdata & 16'h00FF});
    rdr(seia_pkg::IOEXP_OFF);
    ck("upd rd", 32'hA200_3C34, rd);
    wr(seia_pkg::IOEXP_OFF, 32'hA000_0000, 4'h8);
    wr(seia_pkg::IRQ_CLR_OFF, 32'h0000_0002, 4'hF);
    // Reserved select launches nothing
    nq0 = nq;
    wr(seia_pkg::IOEXP_OFF, 32'h3100_0000, 4'h8);
    repeat (30) @(posedge clk);
    ck("rsv jobs", nq0, nq);
    rdr(seia_pkg::IOEXP_OFF);
    ck("rsv data", 0, rd[15:0]);
    // Masked completion keeps irq low until enabled
    wr(seia_pkg::IRQ_EN_OFF, 32'h0000_0000, 4'hF);
    wr(seia_pkg::IOEXP_OFF, 32'h0100_0000, 4'h8);
    repeat (30) @(posedge clk);
    ck("irq mask", 0, irq);
    rdr(seia_pkg::IRQ_STAT_OFF);
    ck("irq stat", 2, rd);
    wr(seia_pkg::IRQ_EN_OFF, 32'h0000_0002, 4'hF);
    ck("irq on", 1, irq);
    wr(seia_pkg::IRQ_CLR_OFF, 32'h0000_0002, 4'hF);
    ck("irq clr", 0, irq);
    complete_run();
  end
endmodule
